// file: hdl/rudp_partition.sv
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// RL1: bits 31 to 16 of the user data base always read zero and store nothing.
// RL2: bits 15 to 10 are a writable field giving where user data space starts.
// RL3: software must write a user base above the kernel program base.
// RL4: bits 9 to 0 always read zero so the boundary is a 1 KB multiple.
// RL5: reset clears the whole register, giving all RAM to kernel data.
// RL6: software must not write a user base above the data RAM size.
// RL7: write data on read-only or unimplemented bits is ignored.
module rudp_partition
(
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    input  wire logic [31:0] kernel_program_ram_base,
    input  wire logic [31:0] data_ram_size,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [31:0] user_data_ram_base,
    output logic             user_space_enable
);

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic        setup;
    logic        wr_udb;
    logic [5:0]  field_q;
    logic [5:0]  wr_field;
    logic [31:0] udb_word;
    logic        mapped;
    rudp_pkg::rudp_status_s status;

    // ------------------------------------------------------------
    // address decode, shared by strobe, error flag and checks
    // ------------------------------------------------------------
    function automatic logic addr_hit
    (
        input logic [11:0] addr,
        input logic [11:0] offset
    );
        return addr == offset;
    endfunction

    // zero-wait slave: access phase completes on its first edge
    assign setup    = psel && !penable;
    assign mapped   = addr_hit(paddr, rudp_pkg::UDB_OFFSET) || addr_hit(paddr, rudp_pkg::KPB_OFFSET)
                   || addr_hit(paddr, rudp_pkg::RSZ_OFFSET) || addr_hit(paddr, rudp_pkg::STAT_OFFSET);
    assign wr_udb   = psel && penable && pwrite && addr_hit(paddr, rudp_pkg::UDB_OFFSET);
    // only byte lane 1 carries the field; other lanes are dropped [RL7]
    assign wr_field = pstrb[1] ? pwdata[rudp_pkg::FIELD_MSB:rudp_pkg::FIELD_LSB] : field_q;
    // upper and lower bits are constant zero [RL1] [RL4]
    assign udb_word = {16'h0000, field_q, 10'h000};

    assign status.user_present = (field_q != 6'h00);
    // software keeps these true; the device only reports them [RL3] [RL6]
    assign status.above_kernel = (udb_word > kernel_program_ram_base);
    assign status.within_size  = (udb_word <= data_ram_size);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    rudp_field u_field
    (
        .sys_clk (sys_clk),
        .reset   (reset),
        .wr_en   (wr_udb),
        .wr_data (wr_field),
        .field_q (field_q)
    );

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= rudp_pkg::READ_ZERO;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            if (setup && !pwrite)
            begin
                unique case (paddr)
                    rudp_pkg::UDB_OFFSET:  prdata <= udb_word;
                    rudp_pkg::KPB_OFFSET:  prdata <= kernel_program_ram_base;
                    rudp_pkg::RSZ_OFFSET:  prdata <= data_ram_size;
                    rudp_pkg::STAT_OFFSET: prdata <= {29'h0, status};
                    default:               prdata <= rudp_pkg::READ_ZERO;
                endcase
            end
            else
                prdata <= rudp_pkg::READ_ZERO;
        end
    end

    // ------------------------------------------------------------
    // partition outputs
    // ------------------------------------------------------------
    // reset gives all RAM to kernel data [RL5]
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            user_data_ram_base <= rudp_pkg::READ_ZERO;
            user_space_enable  <= 1'b0;
        end
        else
        begin
            // reflects the field the edge after it changes [RL2]
            user_data_ram_base <= udb_word;
            user_space_enable  <= status.user_present;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_upper_zero;
        @(posedge sys_clk) disable iff (reset)
        user_data_ram_base[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero"); // [RL1]

    property p_write_lands;
        @(posedge sys_clk) disable iff (reset)
        (wr_udb && pstrb[1]) |-> ##2 user_data_ram_base[15:10] == $past(pwdata[15:10], 2);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("field write lost"); // [RL2]

    property p_low_zero;
        @(posedge sys_clk) disable iff (reset)
        user_data_ram_base[9:0] == 10'h000;
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("low bits not zero"); // [RL4]

    property p_reset_clear;
        @(posedge sys_clk)
        $fell(reset) |-> user_data_ram_base == 32'h0 && !user_space_enable;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("not clear after reset"); // [RL5]

    property p_read_mask;
        @(posedge sys_clk) disable iff (reset)
        (setup && !pwrite && paddr == rudp_pkg::UDB_OFFSET)
            |=> prdata[31:16] == 16'h0 && prdata[9:0] == 10'h0 && pready;
    endproperty
    a_read_mask: assert property (p_read_mask) else $error("read shows dead bits"); // [RL7]

    property p_hold;
        @(posedge sys_clk) disable iff (reset)
        !wr_udb |=> ##1 $stable(user_data_ram_base);
    endproperty
    a_hold: assert property (p_hold) else $error("base changed without write"); // [RL2]

    property p_enable_tracks;
        @(posedge sys_clk) disable iff (reset)
        ##1 user_space_enable == (user_data_ram_base != 32'h0);
    endproperty
    a_enable_tracks: assert property (p_enable_tracks) else $error("enable mismatch"); // [RL2]

    property p_ready_one;
        @(posedge sys_clk) disable iff (reset)
        setup |=> pready ##1 !pready;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("pready not one cycle"); // [RL7]

    // ------------------------------------------------------------
    // storage checks
    // ------------------------------------------------------------
    // a write without lane 1 reaches the cell but must leave it alone
    property p_strobe_off;
        @(posedge sys_clk) disable iff (reset)
        (wr_udb && !pstrb[1]) |=> $stable(field_q);
    endproperty
    a_strobe_off: assert property (p_strobe_off) else $error("field moved without lane 1"); // [RL7]

    property p_ro_write;
        @(posedge sys_clk) disable iff (reset)
        (psel && penable && pwrite && !addr_hit(paddr, rudp_pkg::UDB_OFFSET))
            |=> $stable(field_q);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("stray write moved field"); // [RL7]

    // the base output trails the stored field by exactly one edge
    property p_field_mirror;
        @(posedge sys_clk) disable iff (reset)
        user_data_ram_base[rudp_pkg::FIELD_MSB:rudp_pkg::FIELD_LSB] == $past(field_q);
    endproperty
    a_field_mirror: assert property (p_field_mirror) else $error("base lags field"); // [RL2]

    property p_read_word;
        @(posedge sys_clk) disable iff (reset)
        (setup && !pwrite && addr_hit(paddr, rudp_pkg::UDB_OFFSET))
            |=> prdata[rudp_pkg::FIELD_MSB:rudp_pkg::FIELD_LSB] == $past(field_q);
    endproperty
    a_read_word: assert property (p_read_word) else $error("read field differs"); // [RL2]

    // outputs stay cleared for as long as reset is held
    property p_in_reset;
        @(posedge sys_clk)
        (reset && $past(reset)) |-> user_data_ram_base == 32'h0 && !user_space_enable
            && !pready && prdata == 32'h0;
    endproperty
    a_in_reset: assert property (p_in_reset) else $error("outputs live during reset"); // [RL5]

    c_write: cover property (@(posedge sys_clk) disable iff (reset) wr_udb);
    c_user: cover property (@(posedge sys_clk) disable iff (reset) $rose(user_space_enable));
    c_err: cover property (@(posedge sys_clk) disable iff (reset) pready && pslverr);
    c_read: cover property (@(posedge sys_clk) disable iff (reset)
        setup && !pwrite && addr_hit(paddr, rudp_pkg::UDB_OFFSET));
    c_cut: cover property (@(posedge sys_clk) $rose(reset) && $past(user_space_enable));

endmodule // rudp_partition

`default_nettype wire

// file: hdl/rudp_pkg.sv
`default_nettype none

package rudp_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] UDB_OFFSET   = 12'h000;
    localparam logic [11:0] KPB_OFFSET   = 12'h004;
    localparam logic [11:0] RSZ_OFFSET   = 12'h008;
    localparam logic [11:0] STAT_OFFSET  = 12'h00c;

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int          FIELD_LSB    = 10;
    localparam int          FIELD_MSB    = 15;
    localparam logic [5:0]  FIELD_RESET  = 6'h00;
    localparam logic [31:0] READ_ZERO    = 32'h0000_0000;

    typedef struct packed {
        logic       user_present;
        logic       above_kernel;
        logic       within_size;
    } rudp_status_s;

endpackage : rudp_pkg

`default_nettype wire

// file: hdl/rudp_field.sv
`timescale 1ns/1ps
`default_nettype none

// six-bit storage cell of the partition boundary
module rudp_field
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       wr_en,
    input  wire logic [5:0] wr_data,
    output logic      [5:0] field_q
);

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            field_q <= rudp_pkg::FIELD_RESET;
        else if (wr_en)
            field_q <= wr_data;
    end

endmodule // rudp_field

`default_nettype wire

// file: tb/rudp_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr, uen, err;
    logic [11:0] paddr, a;
    logic [31:0] pwdata, kpb, rsz, prdata, udb, rd, d, w;
    logic [3:0]  pstrb, s;
    logic [5:0]  fld;
    int          n_mismatch, checked;

    rudp_partition u_rudp_partition (.sys_clk(sys_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .kernel_program_ram_base(kpb), .data_ram_size(rsz), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .user_data_ram_base(udb),
        .user_space_enable(uen));

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic end_of_test();
        if (n_mismatch == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // ------------------------------------------------------------
    // apb master, one idle edge before each setup
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd,
                       input logic [3:0] st);
        int n;
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= wd;
        pstrb   <= st;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            n_mismatch++;
            end_of_test();
        end
        else
        begin
            rd = prdata;
            err = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // outputs lag the field by one edge
    task automatic outs();
        repeat (2) @(posedge sys_clk);
        chk("user_data_ram_base", udb, {16'h0000, fld, 10'h000});
        chk("user_space_enable", {31'h0, uen}, {31'h0, fld != 6'h00});
    endtask

    initial
    begin
        {reset, psel, penable, pwrite} = 4'hf;
        {psel, penable, pwrite} = 3'h0;
        {paddr, pwdata, pstrb, kpb, rsz} = '0;
        n_mismatch = 0;
        checked = 0;
        fld = 6'h00;
        void'($urandom(22));
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        outs();
        apb(1'b1, 12'h000, 32'hffff_ffff, 4'hf);
        fld = 6'h3f;
        outs();
        // random traffic, software rules left unkept on purpose
        repeat (40)
        begin
            kpb <= $urandom >> 15;
            rsz <= $urandom >> 15;
            a = 12'($urandom_range(0, 5)) << 2;
            d = $urandom;
            s = 4'($urandom);
            apb(1'b1, a, d, s);
            chk("pslverr_wr", {31'h0, err}, {31'h0, a > 12'h00c});
            chk("prdata_wr", rd, 32'h0000_0000);
            if (a == 12'h000 && s[1])
                fld = d[15:10];
            w = {16'h0000, fld, 10'h000};
            apb(1'b0, a, 32'h0, 4'h0);
            chk("pslverr_rd", {31'h0, err}, {31'h0, a > 12'h00c});
            if (a == 12'h000)
                chk("read_base", rd, w);
            if (a == 12'h004)
                chk("read_kernel", rd, kpb);
            if (a == 12'h008)
                chk("read_size", rd, rsz);
            if (a == 12'h00c)
                chk("read_status", rd, {29'h0, fld != 6'h00, w > kpb, w <= rsz});
            if (a > 12'h00c)
                chk("read_unmapped", rd, 32'h0000_0000);
            outs();
        end
        // software keeps both bounds: above kernel base, within ram size
        kpb <= 32'h0000_2000;
        rsz <= 32'h0000_8000;
        apb(1'b1, 12'h000, 32'h0000_3000, 4'h2);
        fld = 6'h0c;
        apb(1'b0, 12'h00c, 32'h0, 4'h0);
        chk("status_kept", rd, 32'h0000_0007);
        outs();
        // reset in mid-run clears a non-zero field
        apb(1'b1, 12'h000, 32'h0000_8400, 4'h2);
        fld = 6'h21;
        outs();
        reset <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("base_in_reset", udb, 32'h0000_0000);
        chk("enable_in_reset", {31'h0, uen}, 32'h0000_0000);
        reset <= 1'b0;
        fld = 6'h00;
        apb(1'b0, 12'h000, 32'h0, 4'h0);
        chk("read_after_reset", rd, 32'h0000_0000);
        outs();
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
